// ===== src/phy_mgmt_pkg.sv
// Shared indices, field positions, defaults and carriers of the PHY management bank
package phy_mgmt_pkg;

  localparam int IDX_W = 5;
  localparam int DATA_W = 16;

  // Register indices on the indirect access path
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_ID_HIGH = 5'h02;
  localparam logic [4:0] IDX_ID_LOW = 5'h03;
  localparam logic [4:0] IDX_ADV = 5'h04;
  localparam logic [4:0] IDX_LP_ABILITY = 5'h05;
  localparam logic [4:0] IDX_EXPANSION = 5'h06;
  localparam logic [4:0] IDX_MODE = 5'h11;
  localparam logic [4:0] IDX_SPECIAL = 5'h12;
  localparam logic [4:0] IDX_SPECIAL_IND = 5'h1b;
  localparam logic [4:0] IDX_IRQ_SRC = 5'h1d;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h1e;
  localparam logic [4:0] IDX_SPECIAL_CS = 5'h1f;

  // Basic control bit positions
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_ANEG_BIT = 12;
  localparam int CTRL_PDOWN_BIT = 11;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_COLTEST_BIT = 7;

  // Basic status: fixed ability bits 14..11, 3 and 0; live bit positions
  localparam logic [15:0] STAT_FIXED = 16'h7809;
  localparam int STAT_ANEG_DONE_BIT = 5;
  localparam int STAT_RFAULT_BIT = 4;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_JABBER_BIT = 1;

  // Identifier low word field positions
  localparam int ID_OUI_LSB = 10;
  localparam int ID_MODEL_LSB = 4;

  // Advertisement field positions and defaults
  localparam int ADV_RFAULT_BIT = 13;
  localparam int ADV_PAUSE_LSB = 10;
  localparam int ADV_ABIL_LSB = 5;
  localparam logic [1:0] ADV_PAUSE_RESET = 2'h0;
  localparam logic [4:0] ADV_SEL_RESET = 5'h01;

  // Start-up sequencer: two synchroniser stages, then strap capture
  typedef enum logic [1:0] {
    ST_SETTLE1 = 2'b00,
    ST_SETTLE2 = 2'b01,
    ST_CAPTURE = 2'b10,
    ST_RUN = 2'b11
  } init_state_t;

  typedef struct packed {
    logic write;
    logic [4:0] index;
    logic [15:0] wdata;
  } acc_req_t;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic aneg_en;
    logic power_down;
    logic full_duplex;
    logic col_test;
  } ctrl_fields_t;

  // ability bits: [3] 100TX FD, [2] 100TX, [1] 10T FD, [0] 10T
  typedef struct packed {
    logic rfault;
    logic [1:0] pause;
    logic [3:0] ability;
    logic [4:0] selector;
  } adv_fields_t;

  // Indices the decoder recognises
  function automatic logic idx_known(input logic [4:0] idx);
    return (idx <= IDX_EXPANSION) || (idx == IDX_MODE) || (idx == IDX_SPECIAL) ||
           (idx == IDX_SPECIAL_IND) || (idx >= IDX_IRQ_SRC);
  endfunction

  // Control defaults follow the speed strap
  function automatic ctrl_fields_t ctrl_default(input logic strap);
    ctrl_fields_t c;
    c = '0;
    c.speed_100 = strap;
    c.aneg_en = strap;
    return c;
  endfunction

  // Advertisement defaults: 100TX always, other abilities follow the strap
  function automatic adv_fields_t adv_default(input logic strap);
    adv_fields_t a;
    a = '0;
    a.pause = ADV_PAUSE_RESET;
    a.ability = {strap, 1'b1, strap, strap};
    a.selector = ADV_SEL_RESET;
    return a;
  endfunction

endpackage

// ===== src/status_latch.sv
// Latching status flag that holds an event until the status register is read
`timescale 1ns/1ps
module status_latch #(
  parameter bit LATCH_HIGH = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_read,
  input wire logic i_live,
  output logic o_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Hold the latched level; a read or bank reset reloads the live level
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flag <= 1'b0;
    end else if (i_clear || i_read) begin
      o_flag <= i_live; // Event in the read cycle is kept
    end else if (LATCH_HIGH) begin
      o_flag <= o_flag | i_live;
    end else begin
      o_flag <= o_flag & i_live;
    end
  end

endmodule

// ===== src/phy_mgmt_register_bank.sv
// PHY management register bank behind the indirect index and data access path
`timescale 1ns/1ps
module phy_mgmt_register_bank
  import phy_mgmt_pkg::*;
#(
  parameter logic [15:0] OUI_HIGH = 16'h1234, // Arbitrary value
  parameter logic [5:0] OUI_LOW = 6'h15, // Arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h2a, // Arbitrary value
  parameter logic [3:0] REV_NUM = 4'h3 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_speed_strap,
  input wire logic i_acc_valid,
  input wire acc_req_t i_acc_req,
  output logic o_acc_ready,
  output logic o_acc_done,
  output logic [15:0] o_acc_rdata,
  output logic o_ext_hit,
  input wire logic i_link_up,
  input wire logic i_remote_fault,
  input wire logic i_jabber,
  input wire logic i_aneg_done,
  input wire logic i_aneg_speed_100,
  input wire logic i_aneg_full_duplex,
  output logic o_soft_reset,
  output logic o_aneg_restart,
  output logic o_loopback,
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_aneg_enable,
  output logic o_power_down,
  output logic o_col_test,
  output logic [15:0] o_adv_word
);

  init_state_t state_reg;
  init_state_t state_next;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic strap_reg;
  ctrl_fields_t ctrl_reg;
  adv_fields_t adv_reg;
  logic soft_reset_reg;
  logic restart_reg;
  logic aneg_done_reg;
  logic done_reg;
  logic ext_hit_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic speed_reg;
  logic duplex_reg;
  logic take;
  logic wr_ctrl;
  logic wr_adv;
  logic rd_status;
  logic rfault_flag;
  logic jabber_flag;
  logic link_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pin synchroniser
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= i_speed_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Start-up sequence waits for the synchroniser to fill
  always_comb begin
    unique case (state_reg)
      ST_SETTLE1: state_next = ST_SETTLE2;
      ST_SETTLE2: state_next = ST_CAPTURE;
      ST_CAPTURE: state_next = ST_RUN;
      ST_RUN: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_SETTLE1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Strap level caught once after reset; soft reset leaves it alone
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_reg <= 1'b0;
    end else if (state_reg == ST_CAPTURE) begin
      strap_reg <= strap_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode; requests are taken only once the strap is known
  assign o_acc_ready = (state_reg == ST_RUN);
  assign take = i_acc_valid && o_acc_ready;
  assign wr_ctrl = take && i_acc_req.write && (i_acc_req.index == IDX_CTRL);
  assign wr_adv = take && i_acc_req.write && (i_acc_req.index == IDX_ADV);
  assign rd_status = take && !i_acc_req.write && (i_acc_req.index == IDX_STATUS);

  // Self-clearing soft reset and restart pulses
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_reset_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_ctrl && i_acc_req.wdata[CTRL_RESET_BIT];
      restart_reg <= wr_ctrl && i_acc_req.wdata[CTRL_RESTART_BIT] &&
                     !i_acc_req.wdata[CTRL_RESET_BIT];
    end
  end

  // Basic control fields; a reset write ignores the other bits
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= '0;
    end else if (state_reg == ST_CAPTURE) begin
      ctrl_reg <= ctrl_default(strap_sync_reg);
    end else if (soft_reset_reg) begin
      ctrl_reg <= ctrl_default(strap_reg);
    end else if (wr_ctrl && !i_acc_req.wdata[CTRL_RESET_BIT]) begin
      ctrl_reg.loopback <= i_acc_req.wdata[CTRL_LOOP_BIT];
      ctrl_reg.speed_100 <= i_acc_req.wdata[CTRL_SPEED_BIT];
      ctrl_reg.aneg_en <= i_acc_req.wdata[CTRL_ANEG_BIT];
      ctrl_reg.power_down <= i_acc_req.wdata[CTRL_PDOWN_BIT];
      ctrl_reg.full_duplex <= i_acc_req.wdata[CTRL_DUPLEX_BIT];
      ctrl_reg.col_test <= i_acc_req.wdata[CTRL_COLTEST_BIT];
    end
  end

  // Advertisement fields; read-only bits are simply not stored
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      adv_reg <= '0;
    end else if (state_reg == ST_CAPTURE) begin
      adv_reg <= adv_default(strap_sync_reg);
    end else if (soft_reset_reg) begin
      adv_reg <= adv_default(strap_reg);
    end else if (wr_adv) begin
      adv_reg.rfault <= i_acc_req.wdata[ADV_RFAULT_BIT];
      adv_reg.pause <= i_acc_req.wdata[ADV_PAUSE_LSB +: 2];
      adv_reg.ability <= i_acc_req.wdata[ADV_ABIL_LSB +: 4];
      adv_reg.selector <= i_acc_req.wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective speed and duplex: resolved values win under auto-negotiation
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      speed_reg <= 1'b0;
      duplex_reg <= 1'b0;
    end else begin
      speed_reg <= ctrl_reg.aneg_en ? i_aneg_speed_100 : ctrl_reg.speed_100;
      duplex_reg <= ctrl_reg.aneg_en ? i_aneg_full_duplex : ctrl_reg.full_duplex;
    end
  end

  // Completion flag restarts on auto-negotiation disable, power down, restart or soft reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aneg_done_reg <= 1'b0;
    end else if (!ctrl_reg.aneg_en || ctrl_reg.power_down || restart_reg || soft_reset_reg) begin
      aneg_done_reg <= 1'b0;
    end else if (i_aneg_done) begin
      aneg_done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latching status flags, cleared by a status read
  status_latch #(.LATCH_HIGH(1'b1)) u_rfault (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clear(soft_reset_reg),
    .i_read(rd_status),
    .i_live(i_remote_fault),
    .o_flag(rfault_flag)
  );

  status_latch #(.LATCH_HIGH(1'b1)) u_jabber (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clear(soft_reset_reg),
    .i_read(rd_status),
    .i_live(i_jabber),
    .o_flag(jabber_flag)
  );

  status_latch #(.LATCH_HIGH(1'b0)) u_link (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clear(soft_reset_reg),
    .i_read(rd_status),
    .i_live(i_link_up),
    .o_flag(link_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; recognised indices outside this bank read zero here
  always_comb begin
    rdata_next = '0;
    unique case (i_acc_req.index)
      IDX_CTRL: begin
        rdata_next[CTRL_LOOP_BIT] = ctrl_reg.loopback;
        rdata_next[CTRL_SPEED_BIT] = ctrl_reg.speed_100;
        rdata_next[CTRL_ANEG_BIT] = ctrl_reg.aneg_en;
        rdata_next[CTRL_PDOWN_BIT] = ctrl_reg.power_down;
        rdata_next[CTRL_DUPLEX_BIT] = ctrl_reg.full_duplex;
        rdata_next[CTRL_COLTEST_BIT] = ctrl_reg.col_test;
      end
      IDX_STATUS: begin
        rdata_next = STAT_FIXED;
        rdata_next[STAT_ANEG_DONE_BIT] = aneg_done_reg;
        rdata_next[STAT_RFAULT_BIT] = rfault_flag;
        rdata_next[STAT_LINK_BIT] = link_flag;
        rdata_next[STAT_JABBER_BIT] = jabber_flag;
      end
      IDX_ID_HIGH: rdata_next = OUI_HIGH;
      IDX_ID_LOW: rdata_next = {OUI_LOW, MODEL_NUM, REV_NUM};
      IDX_ADV: begin
        rdata_next[ADV_RFAULT_BIT] = adv_reg.rfault;
        rdata_next[ADV_PAUSE_LSB +: 2] = adv_reg.pause;
        rdata_next[ADV_ABIL_LSB +: 4] = adv_reg.ability;
        rdata_next[4:0] = adv_reg.selector;
      end
      default: rdata_next = '0;
    endcase
  end

  // Answer one cycle after the request is taken
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_reg <= 1'b0;
      ext_hit_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      done_reg <= take;
      ext_hit_reg <= take && idx_known(i_acc_req.index) && (i_acc_req.index > IDX_ADV);
      rdata_reg <= (take && !i_acc_req.write) ? rdata_next : '0;
    end
  end

  assign o_acc_done = done_reg;
  assign o_acc_rdata = rdata_reg;
  assign o_ext_hit = ext_hit_reg;
  assign o_soft_reset = soft_reset_reg;
  assign o_aneg_restart = restart_reg;
  assign o_loopback = ctrl_reg.loopback;
  assign o_speed_100 = speed_reg;
  assign o_full_duplex = duplex_reg;
  assign o_aneg_enable = ctrl_reg.aneg_en;
  assign o_power_down = ctrl_reg.power_down;
  assign o_col_test = ctrl_reg.col_test;
  assign o_adv_word = {2'b00, adv_reg.rfault, 1'b0, adv_reg.pause, 1'b0, adv_reg.ability, adv_reg.selector};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence seq_reset_write;
    wr_ctrl && i_acc_req.wdata[CTRL_RESET_BIT];
  endsequence

  sequence seq_restart_write;
    wr_ctrl && i_acc_req.wdata[CTRL_RESTART_BIT] && !i_acc_req.wdata[CTRL_RESET_BIT];
  endsequence

  chk_soft_reset_pulse: assert property (
    seq_reset_write |=> o_soft_reset ##1 (!o_soft_reset && ctrl_reg == ctrl_default(strap_reg)))
    else $error("soft reset did not pulse and restore defaults");

  chk_restart_pulse: assert property (
    seq_restart_write |=> o_aneg_restart ##1 !o_aneg_restart)
    else $error("restart bit did not self-clear");

  chk_strap_defaults: assert property (
    state_reg == ST_CAPTURE |=> o_aneg_enable == strap_reg && ctrl_reg.speed_100 == strap_reg &&
      adv_reg.ability == {strap_reg, 1'b1, strap_reg, strap_reg})
    else $error("strap defaults not applied");

  chk_ctrl_readback: assert property (
    take && !i_acc_req.write && i_acc_req.index == IDX_CTRL |=>
      o_acc_done && o_acc_rdata[10] == 1'b0 && o_acc_rdata[6:0] == 7'h00 &&
      o_acc_rdata[CTRL_RESET_BIT] == 1'b0)
    else $error("control reserved bits not zero");

  chk_status_fixed: assert property (
    take && !i_acc_req.write && i_acc_req.index == IDX_STATUS |=>
      (o_acc_rdata & 16'hf809) == STAT_FIXED)
    else $error("status ability bits wrong");

  chk_jabber_latch: assert property (
    (i_jabber || (jabber_flag && !rd_status)) && !soft_reset_reg |=> jabber_flag)
    else $error("jabber flag not held until read");

  chk_link_latch: assert property (
    !i_link_up && !soft_reset_reg |=> !link_flag)
    else $error("link flag did not latch low");

  chk_rfault_latch: assert property (
    $rose(i_remote_fault) && !soft_reset_reg |=> rfault_flag)
    else $error("remote fault not latched");

  chk_aneg_override: assert property (
    o_aneg_enable && $stable(o_aneg_enable) |=> o_speed_100 == $past(i_aneg_speed_100))
    else $error("manual speed used under auto-negotiation");

  chk_aneg_complete: assert property (
    o_power_down |=> !aneg_done_reg)
    else $error("completion shown while powered down");

  chk_unknown_zero: assert property (
    take && !idx_known(i_acc_req.index) |=> o_acc_rdata == 16'h0000 && !o_ext_hit)
    else $error("unknown index returned data");

  chk_adv_ro_bits: assert property (
    wr_adv |=> o_adv_word[15] == 1'b0 && o_adv_word[9] == 1'b0 &&
      o_adv_word[ADV_RFAULT_BIT] == $past(i_acc_req.wdata[ADV_RFAULT_BIT]))
    else $error("advertisement read-only bits wrong");

  chk_ident_low: assert property (
    take && !i_acc_req.write && i_acc_req.index == IDX_ID_LOW |=>
      o_acc_rdata[15:ID_OUI_LSB] == OUI_LOW && o_acc_rdata[ID_MODEL_LSB +: 6] == MODEL_NUM)
    else $error("identifier fields wrong");

endmodule

// ===== verification/mac_access_model.sv
// Host-side indirect access master that drives the management bank request path
`timescale 1ns/1ps
module mac_access_model
  import phy_mgmt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_acc_ready,
  input wire logic i_acc_done,
  input wire logic [15:0] i_acc_rdata,
  output logic o_acc_valid,
  output acc_req_t o_acc_req
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle request lines at time zero
  initial begin
    o_acc_valid = 1'b0;
    o_acc_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One access: held until the taking edge, released lines show inverted data
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = '0;
    @(negedge i_clk);
    o_acc_valid = 1'b1; // Index and data pair is the only way
    o_acc_req = '{write: wr, index: idx, wdata: wd};
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge i_clk);
      ok = (i_acc_ready === 1'b1);
    end
    @(negedge i_clk);
    o_acc_valid = 1'b0;
    o_acc_req = ~o_acc_req; // Released lines carry no stale value
    ok = ok && (i_acc_done === 1'b1);
    rd = i_acc_rdata;
  endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the PHY management register bank
`timescale 1ns/1ps
module testbench
  import phy_mgmt_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic strap = 1'b1;
  logic link = 1'b1;
  logic rfault = 1'b0;
  logic jab = 1'b0;
  logic an_done = 1'b0;
  logic an_spd = 1'b0;
  logic an_fd = 1'b0;
  logic acc_valid, ready, done, ext_hit, soft_rst, restart, loopback, spd, fd, an_en, pdown, coltest;
  acc_req_t acc_req;
  logic [15:0] rdata, adv_word, rd, pins;
  logic ok;
  int n_fail = 0;
  int samples_checked = 0;
  int i;

  // Clock, 4 ns period
  always #2 i_clk = ~i_clk;

  assign pins = {10'h000, loopback, spd, an_en, pdown, fd, coltest};

  phy_mgmt_register_bank dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_speed_strap(strap),
    .i_acc_valid(acc_valid), .i_acc_req(acc_req), .o_acc_ready(ready), .o_acc_done(done),
    .o_acc_rdata(rdata), .o_ext_hit(ext_hit), .i_link_up(link), .i_remote_fault(rfault),
    .i_jabber(jab), .i_aneg_done(an_done), .i_aneg_speed_100(an_spd), .i_aneg_full_duplex(an_fd),
    .o_soft_reset(soft_rst), .o_aneg_restart(restart), .o_loopback(loopback), .o_speed_100(spd),
    .o_full_duplex(fd), .o_aneg_enable(an_en), .o_power_down(pdown), .o_col_test(coltest),
    .o_adv_word(adv_word));

  mac_access_model mdl_u (.i_clk(i_clk), .i_acc_ready(ready), .i_acc_done(done),
    .i_acc_rdata(rdata), .o_acc_valid(acc_valid), .o_acc_req(acc_req));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare tasks for words and single pins
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware reset with a chosen strap, bounded wait for ready
  task automatic hw_reset(input logic s);
    int n;
    @(negedge i_clk);
    i_arst_n = 1'b0;
    strap = s;
    repeat (4) @(negedge i_clk);
    i_arst_n = 1'b1;
    for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge i_clk);
    if (ready !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED ready expected 1 seen %b", ready);
      tally_and_finish();
    end
  endtask

  // Access through the model; a lost answer ends the run
  task automatic acc(input logic w, input logic [4:0] idx, input logic [15:0] wd);
    mdl_u.access(w, idx, wd, rd, ok);
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED done at index %0d expected 1 seen 0", idx);
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [15:0] e);
    acc(1'b0, idx, 16'h0000);
    chk_word($sformatf("reg %0d", idx), e, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hw_reset(1'b1);
    rd_chk(IDX_CTRL, 16'h3000);
    rd_chk(IDX_STATUS, 16'h7809);
    rd_chk(IDX_STATUS, 16'h780d);
    rd_chk(IDX_ID_HIGH, 16'h1234);
    rd_chk(IDX_ID_LOW, 16'h56a3);
    rd_chk(IDX_ADV, 16'h01e1);
    // Every pause code, all other bits written as ones
    for (i = 0; i < 4; i++) begin
      acc(1'b1, IDX_ADV, 16'hf3ff | (16'(i) << 10));
      rd_chk(IDX_ADV, 16'h21ff | (16'(i) << 10));
      chk_word("adv_word", 16'h21ff | (16'(i) << 10), adv_word);
    end
    // Manual modes, reserved bits and control pins
    acc(1'b1, IDX_CTRL, 16'h49ff);
    rd_chk(IDX_CTRL, 16'h4980);
    chk_word("ctrl pins", 16'h0027, pins);
    acc(1'b1, IDX_CTRL, 16'h2000);
    rd_chk(IDX_CTRL, 16'h2000);
    chk_word("ctrl pins", 16'h0010, pins);
    an_fd = 1'b1;
    acc(1'b1, IDX_CTRL, 16'h3100);
    @(negedge i_clk);
    chk_word("ctrl pins", 16'h000a, pins);
    an_spd = 1'b1;
    an_fd = 1'b0;
    repeat (2) @(negedge i_clk);
    chk_word("ctrl pins", 16'h0018, pins);
    // Restart pulse and self-clearing bit
    acc(1'b1, IDX_CTRL, 16'h1200);
    chk_bit("restart", 1'b1, restart);
    rd_chk(IDX_CTRL, 16'h1000);
    chk_bit("restart", 1'b0, restart);
    // Completion flag, cleared by power down
    an_done = 1'b1;
    @(negedge i_clk);
    an_done = 1'b0;
    rd_chk(IDX_STATUS, 16'h782d);
    acc(1'b1, IDX_CTRL, 16'h1800);
    chk_bit("pdown", 1'b1, pdown);
    rd_chk(IDX_STATUS, 16'h780d);
    acc(1'b1, IDX_CTRL, 16'h1000);
    an_done = 1'b1;
    @(negedge i_clk);
    an_done = 1'b0;
    rd_chk(IDX_STATUS, 16'h782d);
    // One-cycle events held until read, then live again
    rfault = 1'b1;
    jab = 1'b1;
    link = 1'b0;
    @(negedge i_clk);
    rfault = 1'b0;
    jab = 1'b0;
    link = 1'b1;
    repeat (3) @(negedge i_clk);
    rd_chk(IDX_STATUS, 16'h783b);
    rd_chk(IDX_STATUS, 16'h782d);
    // Index sweep: extension hits, unknown indices read zero
    for (i = 5; i < 32; i++) begin
      acc(1'b1, 5'(i), 16'hffff);
      acc(1'b0, 5'(i), 16'h0000);
      chk_bit("ext_hit", i inside {5, 6, 17, 18, 27, 29, 30, 31}, ext_hit);
      if (!(i inside {5, 6, 17, 18, 27, 29, 30, 31})) begin
        chk_word("unknown rd", 16'h0000, rd);
      end
    end
    rd_chk(IDX_CTRL, 16'h1000);
    // Soft reset restores strap defaults; strap not sampled again
    acc(1'b1, IDX_CTRL, 16'h4000);
    strap = 1'b0;
    acc(1'b1, IDX_CTRL, 16'h8000);
    chk_bit("soft_rst", 1'b1, soft_rst);
    repeat (2) @(negedge i_clk);
    rd_chk(IDX_CTRL, 16'h3000);
    rd_chk(IDX_ADV, 16'h01e1);
    rd_chk(IDX_STATUS, 16'h780d);
    // Hardware reset with the strap low
    hw_reset(1'b0);
    rd_chk(IDX_CTRL, 16'h0000);
    rd_chk(IDX_ADV, 16'h0081);
    tally_and_finish();
  end
endmodule
